// [bmc_pkg.sv]
// constants and types shared by the bus matrix configuration block
package bmc_pkg;
    // number of matrix initiators that can raise bus errors
    localparam int unsigned BMC_NUM_INIT = 5;
    // initiator slots, also the bit index within the enable group
    typedef enum logic [2:0] {
        BMC_CPU_FETCH,
        BMC_CPU_DATA,
        BMC_DMA_MASTER,
        BMC_DEBUG_UNIT,
        BMC_SHARED_BUS
    } bmc_init_e;

    // wishbone geometry
    localparam int unsigned BMC_AW = 4;
    localparam int unsigned BMC_DW = 32;
    localparam int unsigned BMC_SW = 4;

    // register byte offsets
    localparam logic [BMC_AW-1:0] BMC_OFS_CONFIG = 4'h0;
    localparam logic [BMC_AW-1:0] BMC_OFS_STATUS = 4'h4;
    localparam logic [BMC_AW-1:0] BMC_OFS_MASK = 4'h8;

    // configuration register field positions
    localparam int unsigned BMC_ERR_EN_LSB = 16;
    localparam int unsigned BMC_ERR_CPU_FETCH_BIT = 16;
    localparam int unsigned BMC_ERR_CPU_DATA_BIT = 17;
    localparam int unsigned BMC_ERR_DMA_BIT = 18;
    localparam int unsigned BMC_ERR_DEBUG_BIT = 19;
    localparam int unsigned BMC_ERR_SHARED_BIT = 20;
    localparam int unsigned BMC_WAIT_BIT = 6;
    localparam int unsigned BMC_ARB_LSB = 0;
    localparam int unsigned BMC_ARB_W = 3;

    // implemented bits and reset value of the configuration register
    localparam logic [BMC_DW-1:0] BMC_CONFIG_WMASK = 32'h001f_0047;
    localparam logic [BMC_DW-1:0] BMC_CONFIG_RESET = 32'h001f_0041;

    // arbitration codes
    localparam logic [BMC_ARB_W-1:0] BMC_ARB_MODE1 = 3'h1;
    localparam logic [BMC_ARB_W-1:0] BMC_ARB_MODE2 = 3'h2;

    // status and mask reset values
    localparam logic [BMC_NUM_INIT-1:0] BMC_STATUS_RESET = 5'h00;
    localparam logic [BMC_NUM_INIT-1:0] BMC_MASK_RESET = 5'h00;
endpackage : bmc_pkg

// [bmc_err_if.sv]
// carrier between the register side and the bus error gate
`timescale 1ns/100ps
interface bmc_err_if #(
    parameter int unsigned N = 5
);
    logic [N-1:0] unmapped;
    logic [N-1:0] enable;
    logic [N-1:0] bus_err;

    modport gate (
        input unmapped,
        input enable,
        output bus_err
    );
    modport ctrl (
        output unmapped,
        output enable,
        input bus_err
    );
endinterface : bmc_err_if

// [bmc_err_gate.sv]
// per-initiator bus error gate for unmapped accesses
`timescale 1ns/100ps
module bmc_err_gate
    import bmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    bmc_err_if.gate eg
);
    // one-cycle error pulse a cycle after an unmapped access, if enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eg.bus_err <= '0;
        end else begin
            eg.bus_err <= eg.unmapped & eg.enable;
        end
    end

    chk_shared_err_gated: assert property (
        @(posedge clk_i) disable iff (rst_i)
        eg.unmapped[BMC_SHARED_BUS] |=>
            eg.bus_err[BMC_SHARED_BUS] == $past(eg.enable[BMC_SHARED_BUS])
    ) else $error("shared bus error not following its enable");

    chk_debug_err_gated: assert property (
        @(posedge clk_i) disable iff (rst_i)
        eg.unmapped[BMC_DEBUG_UNIT] && !eg.enable[BMC_DEBUG_UNIT]
            |=> !eg.bus_err[BMC_DEBUG_UNIT]
    ) else $error("debug unit error raised while disabled");

    chk_dma_err_gated: assert property (
        @(posedge clk_i) disable iff (rst_i)
        eg.unmapped[BMC_DMA_MASTER] && eg.enable[BMC_DMA_MASTER]
            |=> eg.bus_err[BMC_DMA_MASTER]
    ) else $error("dma error missing while enabled");

    // every pulse needs an enabled unmapped access one cycle earlier
    chk_no_spurious_err: assert property (
        @(posedge clk_i) disable iff (rst_i)
        eg.bus_err != '0 |->
            (eg.bus_err & ~($past(eg.unmapped) & $past(eg.enable))) == '0
    ) else $error("bus error without an enabled unmapped access");
endmodule : bmc_err_gate

// [bmc_top.sv]
// bus matrix configuration register with bus error gating and interrupt
`timescale 1ns/100ps
module bmc_top
    import bmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [BMC_AW-1:0] adr_i,
    input wire logic [BMC_SW-1:0] sel_i,
    input wire logic [BMC_DW-1:0] dat_i,
    output logic [BMC_DW-1:0] dat_o,
    output logic ack_o,
    // initiator side
    input wire logic [BMC_NUM_INIT-1:0] unmapped_i,
    output logic [BMC_NUM_INIT-1:0] bus_err_o,
    output logic [BMC_NUM_INIT-1:0] err_en_o,
    output logic data_ram_wait_select_o,
    output logic [BMC_ARB_W-1:0] arbitration_mode_select_o,
    output logic irq_o
);
    // merge write data into a register under byte enables
    function automatic logic [BMC_DW-1:0] bmc_merge(
        input logic [BMC_DW-1:0] old_v,
        input logic [BMC_DW-1:0] new_v,
        input logic [BMC_SW-1:0] sel
    );
        logic [BMC_DW-1:0] res;
        res = old_v;
        for (int i = 0; i < BMC_SW; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : bmc_merge

    logic [BMC_DW-1:0] config_q;
    logic [BMC_NUM_INIT-1:0] status_q;
    logic [BMC_NUM_INIT-1:0] status_d;
    logic [BMC_NUM_INIT-1:0] mask_q;
    logic [BMC_DW-1:0] rdata_d;
    logic req;
    logic wr_cfg;
    logic wr_mask;
    logic rd_status;
    logic [BMC_DW-1:0] cfg_merged;
    logic [BMC_DW-1:0] mask_merged;

    bmc_err_if #(.N(BMC_NUM_INIT)) err_if ();

    // a new request is taken only while no ack is standing
    assign req = cyc_i && stb_i && !ack_o;
    assign wr_cfg = req && we_i && adr_i == BMC_OFS_CONFIG;
    assign wr_mask = req && we_i && adr_i == BMC_OFS_MASK;
    assign rd_status = req && !we_i && adr_i == BMC_OFS_STATUS;
    assign cfg_merged = bmc_merge(config_q, dat_i, sel_i);
    assign mask_merged = bmc_merge({{(BMC_DW-BMC_NUM_INIT){1'b0}}, mask_q},
                                   dat_i, sel_i);

    // single-cycle ack, dropped the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // configuration register; reserved arbitration codes are stored as
    // written since software is trusted to avoid them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            config_q <= BMC_CONFIG_RESET;
        end else if (wr_cfg) begin
            config_q <= cfg_merged & BMC_CONFIG_WMASK;
        end
    end

    // interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= BMC_MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= mask_merged[BMC_NUM_INIT-1:0];
        end
    end

    // sticky error status: a new error wins over a clearing read
    always_comb begin
        status_d = status_q;
        if (rd_status) begin
            status_d = '0;
        end
        status_d = status_d | err_if.bus_err;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= BMC_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // read mux; unmapped offsets answer with zero
    always_comb begin
        rdata_d = '0;
        if (adr_i == BMC_OFS_CONFIG) begin
            rdata_d = config_q;
        end else if (adr_i == BMC_OFS_STATUS) begin
            rdata_d[BMC_NUM_INIT-1:0] = status_q;
        end else if (adr_i == BMC_OFS_MASK) begin
            rdata_d[BMC_NUM_INIT-1:0] = mask_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (req && !we_i) begin
            dat_o <= rdata_d;
        end
    end

    // outputs registered so the matrix sees glitch-free selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_en_o <= BMC_CONFIG_RESET[BMC_ERR_EN_LSB +: BMC_NUM_INIT];
            data_ram_wait_select_o <= BMC_CONFIG_RESET[BMC_WAIT_BIT];
            arbitration_mode_select_o <= BMC_CONFIG_RESET[BMC_ARB_LSB +:
                                                          BMC_ARB_W];
        end else begin
            err_en_o <= config_q[BMC_ERR_EN_LSB +: BMC_NUM_INIT];
            data_ram_wait_select_o <= config_q[BMC_WAIT_BIT];
            arbitration_mode_select_o <=
                config_q[BMC_ARB_LSB +: BMC_ARB_W];
        end
    end

    // irq lags status by one cycle to keep the output a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_q & mask_q);
        end
    end

    // error pulses leave straight from the gate's flops
    assign err_if.unmapped = unmapped_i;
    assign err_if.enable = config_q[BMC_ERR_EN_LSB +: BMC_NUM_INIT];
    assign bus_err_o = err_if.bus_err;

    bmc_err_gate u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .eg(err_if.gate)
    );

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_cfg_write;
        req && we_i && adr_i == BMC_OFS_CONFIG && sel_i == 4'hf;
    endsequence

    chk_cfg_write_lands: assert property (
        s_cfg_write |=> config_q == ($past(dat_i) & BMC_CONFIG_WMASK)
    ) else $error("configuration write did not land masked");

    chk_reserved_zero: assert property (
        (config_q & ~BMC_CONFIG_WMASK) == '0
    ) else $error("unimplemented configuration bit is set");

    chk_enables_follow: assert property (
        s_cfg_write |=> ##1
            err_en_o == $past(dat_i[BMC_ERR_EN_LSB +: BMC_NUM_INIT], 2)
    ) else $error("error enables not following configuration");

    chk_wait_follow: assert property (
        s_cfg_write |=> ##1
            data_ram_wait_select_o == $past(dat_i[BMC_WAIT_BIT], 2)
    ) else $error("wait select not following configuration");

    chk_arb_follow: assert property (
        s_cfg_write |=> ##1
            arbitration_mode_select_o ==
                $past(dat_i[BMC_ARB_LSB +: BMC_ARB_W], 2)
    ) else $error("arbitration select not following configuration");

    chk_ack_single: assert property (
        ack_o |=> !ack_o
    ) else $error("ack stood for more than one cycle");

    chk_status_sticky: assert property (
        err_if.bus_err != '0 |=>
            (status_q & $past(err_if.bus_err)) == $past(err_if.bus_err)
    ) else $error("error event lost from status");

    sequence s_status_read;
        rd_status;
    endsequence

    // a clearing read leaves only the errors of that same cycle
    chk_status_clear: assert property (
        s_status_read |=> status_q == $past(err_if.bus_err)
    ) else $error("status read did not clear or lost a new error");

    chk_irq_quiet: assert property (
        (status_q & mask_q) == '0 |=> !irq_o
    ) else $error("interrupt raised without unmasked status");

    chk_irq_level: assert property (
        (status_q & mask_q) != '0 |=> irq_o
    ) else $error("interrupt not raised for unmasked status");
endmodule : bmc_top

// [bmc_init_model.sv]
// behavioural model of the matrix initiators raising unmapped accesses
`timescale 1ns/100ps
module bmc_init_model
    import bmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [BMC_NUM_INIT-1:0] req_i,
    output logic [BMC_NUM_INIT-1:0] unmapped_o
);
    // one registered pulse per request, back to back allowed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unmapped_o <= '0;
        end else begin
            unmapped_o <= req_i;
        end
    end
endmodule : bmc_init_model

// [tb_top.sv]
// self-checking bench for the bus matrix configuration block
`timescale 1ns/100ps
module tb_top;
    import bmc_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc_i = 0, stb_i = 0, we_i = 0;
    logic [3:0] adr_i = 0, sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, rd;
    logic ack_o, wait_o, irq_o;
    logic [2:0] arb_o;
    logic [4:0] req = 0, unm, err_o, en_o, exp_err = 0;
    logic [31:0] cfg_m = BMC_CONFIG_RESET, lf = 32'h0001_105d;
    logic [4:0] st_m = 0, msk_m = 0;
    int n_mismatch = 0, cmp_count = 0;

    bmc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .unmapped_i(unm),
        .bus_err_o(err_o), .err_en_o(en_o),
        .data_ram_wait_select_o(wait_o),
        .arbitration_mode_select_o(arb_o), .irq_o(irq_o));
    bmc_init_model ini (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .unmapped_o(unm));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task results;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // classic single cycle; only the watchdog ends a wait for ack
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] s);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
        @(posedge clk_i);
    endtask : wb

    task rd_chk(input logic [3:0] a, input logic [31:0] e);
        wb(0, a, 0, 4'h0);
        chk(rd, e);
    endtask : rd_chk

    // model keeps only implemented bits of enabled bytes
    task wr_cfg(input logic [31:0] d, input logic [3:0] s);
        int b;
        wb(1, BMC_OFS_CONFIG, d, s);
        for (b = 0; b < 4; b++) begin
            if (s[b]) cfg_m[b*8+:8] = d[b*8+:8] & BMC_CONFIG_WMASK[b*8+:8];
        end
        repeat (2) @(posedge clk_i);
        chk(en_o, cfg_m[20:16]);
        chk(wait_o, cfg_m[6]);
        chk(arb_o, cfg_m[2:0]);
    endtask : wr_cfg

    task fire(input int n);
        repeat (n) begin
            lf = lfsr(lf);
            req <= lf[4:0];
            @(posedge clk_i);
        end
        req <= 0;
        repeat (5) @(posedge clk_i);
    endtask : fire

    // error pulses checked every cycle against enables at the taking edge
    always @(posedge clk_i) begin
        if (rst_i) exp_err = 0;
        else begin
            chk(err_o, exp_err);
            exp_err = unm & cfg_m[20:16];
            st_m = st_m | exp_err;
        end
    end

    initial begin
        #800000;
        n_mismatch++;
        results();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rd_chk(BMC_OFS_CONFIG, 32'h001f_0041);
        chk({en_o, wait_o, arb_o}, {5'h1f, 1'b1, 3'h1});
        rd_chk(BMC_OFS_STATUS, 32'h0);
        rd_chk(BMC_OFS_MASK, 32'h0);
        wr_cfg(32'hffff_fffa, 4'hf);
        rd_chk(BMC_OFS_CONFIG, 32'h001f_0042);
        wb(1, 4'hc, 32'hffff_ffff, 4'hf);
        rd_chk(4'hc, 32'h0);
        rd_chk(BMC_OFS_MASK, 32'h0);
        wr_cfg(32'h0000_0001, 4'h4);
        rd_chk(BMC_OFS_CONFIG, cfg_m);
        fire(20);
        rd_chk(BMC_OFS_STATUS, 32'h0);
        // software keeps arbitration codes at 001 or 010
        for (int i = 0; i < 40; i++) begin
            lf = lfsr(lf);
            wr_cfg((lf & 32'h001f_0040) | (lf[7] ? 32'h2 : 32'h1),
                   4'hf);
            lf = lfsr(lf);
            msk_m = lf[4:0];
            wb(1, BMC_OFS_MASK, {27'h0, msk_m}, 4'h1);
            fire(6);
            chk(irq_o, |(st_m & msk_m));
            rd_chk(BMC_OFS_STATUS, {27'h0, st_m});
            st_m = 0;
            repeat (2) @(posedge clk_i);
            chk(irq_o, 1'b0);
        end
        results();
    end
endmodule : tb_top
